// ---- pwr_seq_pkg.sv ----
// Purpose: constants and types shared by the power-mode sequencer files
// Assumes: 100 MHz clock, one-second activity tick derived locally
package pwr_seq_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam logic [15:0] PC_LIMIT_RST = 16'h0e10; // 3600 s
    localparam logic [7:0] SLEEP_V_RST = 8'h05;
    localparam logic [7:0] SLEEP_I_RST = 8'h14;
    localparam logic [7:0] BUS_LOW_RST = 8'h05;
    localparam logic [15:0] SHUTDOWN_MV_RST = 16'h1b58; // 7000 mV
    localparam int SLOT_PU_CYCLES = 2; // pull-up settle before sample
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_REMOVED = 2'b10,
        MODE_SHUTDOWN = 2'b11
    } pwr_mode_t;
endpackage

// ---- tick_if.sv ----
// Purpose: carries the shared tick and slot strobes between sequencer modules
// Assumes: single clock domain
// Notes: driven by the tick generator only
interface tick_if;
    logic tick;
    logic pu_on;
    logic sample;
    modport gen (output tick, output pu_on, output sample);
    modport use_p (input tick, input pu_on, input sample);
endinterface

// ---- sec_tick_gen.sv ----
// Purpose: one-second tick and presence slot strobes
// Assumes: synchronous active-high reset
// Notes: slot pulls up for a few cycles then samples
module sec_tick_gen
    import pwr_seq_pkg::*;
#(
    parameter int PERIOD = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    tick_if.gen t
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic wrap;

    // count up to one tick per period
    assign wrap = (cnt_q == 32'(PERIOD - 1));
    assign cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;
    assign t.tick = wrap;
    // pull-up pulse opens the slot, sample at its end
    assign t.pu_on = (cnt_q < 32'(SLOT_PU_CYCLES + 1));
    assign t.sample = (cnt_q == 32'(SLOT_PU_CYCLES));

    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_q <= 32'h0;
        else cnt_q <= cnt_d;
    end
endmodule

// ---- power_mode_precharge_ctl.sv ----
// Purpose: power-mode sequencer with precharge timeout supervisor
// Assumes: measurements arrive as signed mA and unsigned mV from same-clock logic; pins are synchronised here
// Notes: long counts shortened via TICK_PERIOD parameter
module power_mode_precharge_ctl
    import pwr_seq_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic signed [15:0] current_ma_i,
    input wire logic [15:0] voltage_mv_i,
    input wire logic [15:0] pack_mv_i,
    input wire logic signed [15:0] temp_dk_i,
    input wire logic signed [15:0] chg_thresh_ma_i,
    input wire logic signed [15:0] dsg_thresh_ma_i,
    input wire logic [7:0] sleep_ma_i,
    input wire logic [7:0] sleep_v_time_i,
    input wire logic [7:0] sleep_i_time_i,
    input wire logic [7:0] bus_low_time_i,
    input wire logic signed [15:0] cal_inhibit_lo_i,
    input wire logic signed [15:0] cal_inhibit_hi_i,
    input wire logic [15:0] shutdown_mv_i,
    input wire logic [15:0] charger_present_mv_i,
    input wire logic [15:0] precharge_timeout_limit_i,
    input wire logic precharge_timeout_action_en_i,
    input wire logic zero_volt_cfg_hi_i,
    input wire logic zero_volt_cfg_lo_i,
    input wire logic no_removal_option_i,
    input wire logic no_removal_keep_charge_i,
    input wire logic sleep_en_i,
    input wire logic pulse_charge_off_flag_i,
    input wire logic precharge_phase_flag_i,
    input wire logic overcurrent_dsg_flag_i,
    input wire logic overcurrent_dsg_tier2_flag_i,
    input wire logic afe_overcurrent_dsg_flag_i,
    input wire logic afe_short_dsg_flag_i,
    input wire logic overcurrent_chg_flag_i,
    input wire logic overcurrent_chg_tier2_flag_i,
    input wire logic afe_short_chg_flag_i,
    input wire logic permanent_failure_flag_i,
    input wire logic recovery_timer_active_i,
    input wire logic status_change_i,
    input wire logic sleep_cmd_i,
    input wire logic shutdown_cmd_i,
    input wire logic chg_alg_chg_on_i,
    input wire logic chg_alg_dsg_on_i,
    input wire logic chg_alg_zv_on_i,
    input wire logic [15:0] chg_alg_current_i,
    input wire logic [15:0] chg_alg_voltage_i,
    input wire logic pack_present_input_i,
    input wire logic bus_clock_pin_i,
    input wire logic bus_data_pin_i,
    output logic presence_pullup_pin_o,
    output logic presence_pullup_pin_oe_n_o,
    output logic charge_switch_o,
    output logic discharge_switch_o,
    output logic zero_volt_charge_switch_o,
    output logic [15:0] charge_current_req_o,
    output logic [15:0] charge_voltage_req_o,
    output logic terminate_charge_alarm_o,
    output logic terminate_discharge_alarm_o,
    output logic precharge_timeout_flag_o,
    output logic discharge_current_fault_flag_o,
    output logic pack_present_flag_o,
    output logic wake_flag_o,
    output logic init_flag_o,
    output logic afe_config_o,
    output logic afe_shutdown_o,
    output logic cal_start_o,
    output logic meas_volt_o,
    output logic meas_curr_o,
    output pwr_mode_t mode_o
);
    // ***
    // timing and pin synchronisers
    // ***
    tick_if tk();
    sec_tick_gen #(.PERIOD(TICK_PERIOD)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(tk)
    );

    logic [2:0] pack_present_input_s1_q, pack_present_input_s2_q;
    logic [2:0] sync_in;
    logic scl_prev_q, sda_prev_q;
    assign sync_in = {bus_data_pin_i, bus_clock_pin_i, pack_present_input_i};

    // two flops before any logic reads a pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pack_present_input_s1_q <= 3'h7;
            pack_present_input_s2_q <= 3'h7;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            pack_present_input_s1_q <= sync_in;
            pack_present_input_s2_q <= pack_present_input_s1_q;
            scl_prev_q <= pack_present_input_s2_q[1];
            sda_prev_q <= pack_present_input_s2_q[2];
        end
    end

    logic pack_present_input_pin, scl, sda, bus_rise, bus_low;
    assign pack_present_input_pin = pack_present_input_s2_q[0];
    assign scl = pack_present_input_s2_q[1];
    assign sda = pack_present_input_s2_q[2];
    assign bus_rise = (scl & ~scl_prev_q) | (sda & ~sda_prev_q);
    assign bus_low = ~scl & ~sda;

    // ***
    // presence sampling
    // ***
    logic present_q, seen_high_q;
    logic remove_det, pack_present_input_cycle;
    assign remove_det = ~no_removal_option_i; // input ignored when option set
    // pull-up driven only during the slot; enable low while driving
    assign presence_pullup_pin_o = 1'b1;
    assign presence_pullup_pin_oe_n_o = ~tk.pu_on;
    // pin high-then-low seen across samples
    assign pack_present_input_cycle = remove_det & tk.sample & ~pack_present_input_pin & seen_high_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            present_q <= 1'b1;
            seen_high_q <= 1'b0;
        end else if (tk.sample && remove_det) begin
            present_q <= ~pack_present_input_pin;
            if (pack_present_input_pin) seen_high_q <= 1'b1;
            else seen_high_q <= 1'b0;
        end
    end
    assign pack_present_flag_o = present_q;

    // ***
    // precharge timeout supervisor
    // ***
    logic [15:0] pc_timer_q;
    logic pc_run_q, pc_to_q;
    logic pc_en, pc_hold, pc_start, pc_expire, pc_recover;
    assign pc_en = (precharge_timeout_limit_i != 16'h0);
    assign pc_start = (current_ma_i >= chg_thresh_ma_i);
    assign pc_hold = pulse_charge_off_flag_i | ~precharge_phase_flag_i;
    assign pc_expire = pc_en & pc_run_q & (pc_timer_q >= precharge_timeout_limit_i);
    assign pc_recover = pc_to_q & ((current_ma_i >= -dsg_thresh_ma_i) | pack_present_input_cycle);

    // timer advances only on the shared second tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_timer_q <= 16'h0;
            pc_run_q <= 1'b0;
            pc_to_q <= 1'b0;
        end else begin
            if (!pc_en || pc_recover) begin
                pc_timer_q <= 16'h0;
                pc_run_q <= 1'b0;
                pc_to_q <= 1'b0;
            end else begin
                if (pc_start) pc_run_q <= 1'b1;
                if (tk.tick && pc_run_q && !pc_hold && !pc_to_q && pc_timer_q != 16'hffff) begin
                    pc_timer_q <= pc_timer_q + 16'h1;
                end
                if (pc_expire) pc_to_q <= 1'b1;
            end
        end
    end
    assign precharge_timeout_flag_o = pc_to_q;

    logic pc_act, zv_cfg;
    assign pc_act = pc_to_q & precharge_timeout_action_en_i;
    assign zv_cfg = zero_volt_cfg_hi_i | zero_volt_cfg_lo_i;

    // ***
    // discharge-current fault and safety summary
    // ***
    logic dsg_fault, sleep_block_flags;
    assign dsg_fault = overcurrent_dsg_flag_i | overcurrent_dsg_tier2_flag_i
                     | afe_overcurrent_dsg_flag_i | afe_short_dsg_flag_i;
    assign sleep_block_flags = dsg_fault | overcurrent_chg_flag_i | overcurrent_chg_tier2_flag_i
                             | afe_short_chg_flag_i | permanent_failure_flag_i;
    assign discharge_current_fault_flag_o = dsg_fault;

    // ***
    // mode sequencer
    // ***
    pwr_mode_t mode_q, mode_d;
    logic [7:0] bus_low_cnt_q, sv_cnt_q, si_cnt_q;
    logic [7:0] abs_i;
    logic sleep_ok, sleep_go, sleep_exit, removed, shut_go, to_sleep;
    logic cal_inhibit, wake_q, init_q, afe_cfg_q, cal_q, pwr_init_q;

    assign abs_i = current_ma_i[15] ? ((-current_ma_i > 16'sd255) ? 8'hff : 8'((-current_ma_i)))
                                    : ((current_ma_i > 16'sd255) ? 8'hff : 8'(current_ma_i));
    assign removed = remove_det & ~present_q;
    // either low-bus path or discharge-plus-command path
    assign sleep_go = sleep_en_i & (((abs_i <= sleep_ma_i) & (bus_low_cnt_q >= bus_low_time_i))
                    | (current_ma_i <= 16'sd0 & abs_i <= sleep_ma_i & sleep_cmd_i))
                    & (~remove_det | ~present_q);
    assign sleep_ok = ~sleep_block_flags & ~recovery_timer_active_i
                    & (sleep_v_time_i != 8'h0) & (sleep_i_time_i != 8'h0);
    assign sleep_exit = (current_ma_i != 16'sd0) | bus_rise | status_change_i
                      | (remove_det & present_q);
    assign shut_go = ((voltage_mv_i <= shutdown_mv_i) & (current_ma_i <= 16'sd0))
                   | (shutdown_cmd_i & (current_ma_i == 16'sd0)
                      & (pack_mv_i < charger_present_mv_i));
    // calibration inhibited only inside the band, as written
    assign cal_inhibit = (temp_dk_i <= cal_inhibit_lo_i) & (temp_dk_i >= cal_inhibit_hi_i);
    assign to_sleep = (mode_q == MODE_NORMAL) & sleep_go & sleep_ok & ~shut_go;

    // next mode; shutdown wins over everything
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_NORMAL: begin
                if (shut_go) mode_d = MODE_SHUTDOWN;
                else if (removed) mode_d = MODE_REMOVED;
                else if (to_sleep) mode_d = MODE_SLEEP;
            end
            MODE_SLEEP: begin
                if (shut_go) mode_d = MODE_SHUTDOWN;
                else if (sleep_exit) mode_d = MODE_NORMAL;
            end
            MODE_REMOVED: begin
                if (shut_go) mode_d = MODE_SHUTDOWN;
                else if (!removed) mode_d = MODE_NORMAL;
            end
            MODE_SHUTDOWN: mode_d = MODE_SHUTDOWN; // only power-on reset leaves
        endcase
    end

    // bus-low timer and sleep sample periods on the second tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_NORMAL;
            bus_low_cnt_q <= 8'h0;
            sv_cnt_q <= 8'h0;
            si_cnt_q <= 8'h0;
        end else begin
            mode_q <= mode_d;
            if (!bus_low) bus_low_cnt_q <= 8'h0;
            else if (tk.tick && bus_low_cnt_q != 8'hff) bus_low_cnt_q <= bus_low_cnt_q + 8'h1;
            if (mode_q != MODE_SLEEP) begin
                sv_cnt_q <= 8'h0;
                si_cnt_q <= 8'h0;
            end else if (tk.tick) begin
                sv_cnt_q <= (sv_cnt_q + 8'h1 >= sleep_v_time_i) ? 8'h0 : sv_cnt_q + 8'h1;
                si_cnt_q <= (si_cnt_q + 8'h1 >= sleep_i_time_i) ? 8'h0 : si_cnt_q + 8'h1;
            end
        end
    end

    // measurement strobes: every tick in normal, per period in sleep
    assign meas_volt_o = tk.tick & ((mode_q == MODE_NORMAL) | (mode_q == MODE_REMOVED)
                       | ((mode_q == MODE_SLEEP) & (sv_cnt_q + 8'h1 >= sleep_v_time_i)));
    assign meas_curr_o = tk.tick & ((mode_q == MODE_NORMAL) | (mode_q == MODE_REMOVED)
                       | ((mode_q == MODE_SLEEP) & (si_cnt_q + 8'h1 >= sleep_i_time_i)));

    // power-up: wake set, front end configured, flags cleared after one second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b1;
            init_q <= 1'b1;
            afe_cfg_q <= 1'b0;
            pwr_init_q <= 1'b1;
            cal_q <= 1'b0;
        end else begin
            afe_cfg_q <= pwr_init_q;
            pwr_init_q <= 1'b0;
            if (tk.tick) begin
                wake_q <= 1'b0;
                init_q <= 1'b0;
            end
            cal_q <= (mode_q == MODE_NORMAL) & (mode_d == MODE_SLEEP) & ~cal_inhibit;
        end
    end
    assign wake_flag_o = wake_q;
    assign init_flag_o = init_q;
    assign afe_config_o = afe_cfg_q;
    assign cal_start_o = cal_q;

    // ***
    // switch, request and alarm outputs
    // ***
    logic chg_d, dsg_d, zv_d, tca_d, tda_d, req_zero;
    logic chg_q, dsg_q, zv_q, tca_q, tda_q, shut_q;
    logic [15:0] ireq_q, vreq_q;
    logic in_sleep, in_rem, in_shut;
    assign in_sleep = (mode_d == MODE_SLEEP);
    assign in_rem = (mode_d == MODE_REMOVED);
    assign in_shut = (mode_d == MODE_SHUTDOWN);
    assign req_zero = pc_act | in_rem | in_shut;
    // charger algorithm drives switches unless a fault or mode forces them off
    assign chg_d = chg_alg_chg_on_i & ~pc_act & ~in_rem & ~in_shut
                 & ~(in_sleep & ~no_removal_keep_charge_i);
    assign dsg_d = chg_alg_dsg_on_i & ~in_rem & ~in_shut & ~(in_sleep & remove_det);
    assign zv_d = chg_alg_zv_on_i & ~(zv_cfg & (pc_act | in_rem | in_sleep)) & ~in_shut;
    // charge alarm set by timeout action or removed mode, discharge alarm by removed mode; a discharge fault only holds the discharge alarm
    assign tca_d = pc_act | in_rem;
    assign tda_d = in_rem | (dsg_fault & tda_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chg_q <= 1'b0;
            dsg_q <= 1'b0;
            zv_q <= 1'b0;
            tca_q <= 1'b0;
            tda_q <= 1'b0;
            shut_q <= 1'b0;
            ireq_q <= 16'h0;
            vreq_q <= 16'h0;
        end else begin
            chg_q <= chg_d;
            dsg_q <= dsg_d;
            zv_q <= zv_d;
            tca_q <= tca_d;
            tda_q <= tda_d;
            shut_q <= in_shut;
            ireq_q <= req_zero ? 16'h0 : chg_alg_current_i;
            vreq_q <= req_zero ? 16'h0 : chg_alg_voltage_i;
        end
    end
    assign charge_switch_o = chg_q;
    assign discharge_switch_o = dsg_q;
    assign zero_volt_charge_switch_o = zv_q;
    assign terminate_charge_alarm_o = tca_q;
    assign terminate_discharge_alarm_o = tda_q;
    assign afe_shutdown_o = shut_q;
    assign charge_current_req_o = ireq_q;
    assign charge_voltage_req_o = vreq_q;
    assign mode_o = mode_q;
endmodule

// ---- power_mode_precharge_ctl_sva.sv ----
// Purpose: port-level checks for the power-mode sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top file
module power_mode_precharge_ctl_sva
    import pwr_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] precharge_timeout_limit_i,
    input wire logic precharge_timeout_action_en_i,
    input wire logic permanent_failure_flag_i,
    input wire logic overcurrent_dsg_flag_i,
    input wire logic overcurrent_dsg_tier2_flag_i,
    input wire logic afe_overcurrent_dsg_flag_i,
    input wire logic afe_short_dsg_flag_i,
    input wire logic presence_pullup_pin_oe_n_o,
    input wire logic charge_switch_o,
    input wire logic discharge_switch_o,
    input wire logic zero_volt_charge_switch_o,
    input wire logic [15:0] charge_current_req_o,
    input wire logic terminate_charge_alarm_o,
    input wire logic terminate_discharge_alarm_o,
    input wire logic precharge_timeout_flag_o,
    input wire logic discharge_current_fault_flag_o,
    input wire logic afe_shutdown_o,
    input wire logic cal_start_o,
    input wire pwr_mode_t mode_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ***
    // properties
    // ***
    property p_fault_or;
        discharge_current_fault_flag_o == (overcurrent_dsg_flag_i | overcurrent_dsg_tier2_flag_i |
            afe_overcurrent_dsg_flag_i | afe_short_dsg_flag_i);
    endproperty
    a_fault_or: assert property (p_fault_or) else $error("fault flag differs from its sources");
    property p_pc_action;
        precharge_timeout_flag_o && precharge_timeout_action_en_i |=> !charge_switch_o &&
            charge_current_req_o == 16'h0000 && terminate_charge_alarm_o;
    endproperty
    a_pc_action: assert property (p_pc_action) else $error("timeout action not applied");
    property p_pc_disabled;
        precharge_timeout_limit_i == 16'h0000 [*2] |-> !precharge_timeout_flag_o;
    endproperty
    a_pc_disabled: assert property (p_pc_disabled) else $error("timeout raised with zero limit");
    // the slot holds the pull-up for exactly three cycles
    property p_pullup;
        $fell(presence_pullup_pin_oe_n_o) |-> !presence_pullup_pin_oe_n_o [*3] ##1 presence_pullup_pin_oe_n_o;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up slot length wrong");
    property p_removed;
        mode_o == MODE_REMOVED && $past(mode_o) == MODE_REMOVED |-> terminate_charge_alarm_o &&
            terminate_discharge_alarm_o && !charge_switch_o && !discharge_switch_o;
    endproperty
    a_removed: assert property (p_removed) else $error("removed state outputs wrong");
    property p_shut_hold;
        mode_o == MODE_SHUTDOWN |=> mode_o == MODE_SHUTDOWN && !charge_switch_o && !discharge_switch_o &&
            !zero_volt_charge_switch_o && afe_shutdown_o;
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("shutdown outputs wrong");
    property p_pf_block;
        mode_o == MODE_NORMAL && permanent_failure_flag_i |=> mode_o != MODE_SLEEP;
    endproperty
    a_pf_block: assert property (p_pf_block) else $error("sleep entered with failure flag");
    property p_cal_pulse;
        cal_start_o |-> mode_o == MODE_SLEEP ##1 !cal_start_o;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibration start outside sleep entry");
endmodule

// ---- pack_presence_model.sv ----
// Purpose: pack-side model of the presence line
// Assumes: pull-up drives only while its enable is low
// Notes: a released, undriven line toggles so a stale level never passes
module pack_presence_model (
    input wire logic clk_i,
    input wire logic inserted_i,
    input wire logic pullup_i,
    input wire logic pullup_oe_n_i,
    output logic pack_present_input_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_q = 1'b0;
    // undefined level of a floating pin
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // inserted pack grounds the line, else only the pull-up defines it
    assign pack_present_input_o = inserted_i ? 1'b0 : (!pullup_oe_n_i ? pullup_i : float_q);
endmodule

// ---- test_power_mode_precharge_ctl.sv ----
// Purpose: self-checking bench for the power-mode sequencer
// Assumes: short activity period via TICK_PERIOD
// Notes: scenarios run in sequence, shutdown last since only reset leaves it
module test_power_mode_precharge_ctl;
    import pwr_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TP = 20; // short tick keeps the run brief
    logic clk_i = 1'b0, rst_i = 1'b1, inserted, cal_seen;
    logic signed [15:0] current_ma_i, temp_dk_i, chg_thresh_ma_i, dsg_thresh_ma_i, cal_inhibit_lo_i, cal_inhibit_hi_i;
    logic [15:0] voltage_mv_i, pack_mv_i, shutdown_mv_i, charger_present_mv_i, precharge_timeout_limit_i;
    logic [15:0] chg_alg_current_i, chg_alg_voltage_i, charge_current_req_o, charge_voltage_req_o;
    logic [7:0] sleep_ma_i, sleep_v_time_i, sleep_i_time_i, bus_low_time_i;
    logic precharge_timeout_action_en_i, zero_volt_cfg_hi_i, zero_volt_cfg_lo_i, no_removal_option_i;
    logic no_removal_keep_charge_i, sleep_en_i, pulse_charge_off_flag_i, precharge_phase_flag_i;
    logic overcurrent_dsg_flag_i, overcurrent_dsg_tier2_flag_i, afe_overcurrent_dsg_flag_i, afe_short_dsg_flag_i;
    logic overcurrent_chg_flag_i, overcurrent_chg_tier2_flag_i, afe_short_chg_flag_i, permanent_failure_flag_i;
    logic recovery_timer_active_i, status_change_i, sleep_cmd_i, shutdown_cmd_i, chg_alg_chg_on_i, chg_alg_dsg_on_i;
    logic chg_alg_zv_on_i, pack_present_input_i, bus_clock_pin_i, bus_data_pin_i, presence_pullup_pin_o;
    logic presence_pullup_pin_oe_n_o, charge_switch_o, discharge_switch_o, zero_volt_charge_switch_o;
    logic terminate_charge_alarm_o, terminate_discharge_alarm_o, precharge_timeout_flag_o, pack_present_flag_o;
    logic discharge_current_fault_flag_o, wake_flag_o, init_flag_o, afe_config_o, afe_shutdown_o, cal_start_o;
    logic meas_volt_o, meas_curr_o;
    pwr_mode_t mode_o;
    int bad_count = 0, checked = 0;
    // ***
    // clock, design and pack model
    // ***
    always #5 clk_i = ~clk_i;
    power_mode_precharge_ctl #(.TICK_PERIOD(TP)) power_mode_precharge_ctl_inst (.*);
    pack_presence_model pack_presence_model_inst (.clk_i(clk_i), .inserted_i(inserted),
        .pullup_i(presence_pullup_pin_o), .pullup_oe_n_i(presence_pullup_pin_oe_n_o), .pack_present_input_o(pack_present_input_i));
    // remember a calibration pulse, it lasts a single cycle
    always @(posedge clk_i) if (cal_start_o === 1'b1) cal_seen <= 1'b1;
    // ***
    // helpers
    // ***
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs always change 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ***
    // scenarios
    // ***
    task automatic t_wake();
        chk("wake", wake_flag_o, 1'b1);
        chk("mode", mode_o, MODE_NORMAL);
        step(1);
        chk("afe cfg", afe_config_o, 1'b1);
        step(3 * TP - 1);
        chk("wake", wake_flag_o, 1'b0);
        chk("init", init_flag_o, 1'b0);
    endtask
    task automatic t_precharge();
        precharge_timeout_limit_i = 16'h0003;
        current_ma_i = 16'sh0032; // below threshold, timer idle
        step(6 * TP);
        chk("timeout", precharge_timeout_flag_o, 1'b0);
        current_ma_i = 16'sh01f4;
        pulse_charge_off_flag_i = 1'b1;
        step(6 * TP);
        chk("timeout", precharge_timeout_flag_o, 1'b0);
        pulse_charge_off_flag_i = 1'b0;
        step(TP);
        chk("timeout", precharge_timeout_flag_o, 1'b0);
        for (int k = 0; k < 4 * TP && precharge_timeout_flag_o !== 1'b1; k++) step(1);
        step(2);
        chk("timeout", precharge_timeout_flag_o, 1'b1);
        chk("charge sw", charge_switch_o, 1'b0);
        chk("zero volt sw", zero_volt_charge_switch_o, 1'b0);
        chk("req current", charge_current_req_o, 16'h0000);
        chk("req voltage", charge_voltage_req_o, 16'h0000);
        chk("chg alarm", terminate_charge_alarm_o, 1'b1);
        current_ma_i = 16'sh03e8; // at the negated discharge threshold
        precharge_phase_flag_i = 1'b0;
        step(3);
        chk("timeout", precharge_timeout_flag_o, 1'b0);
        chk("chg alarm", terminate_charge_alarm_o, 1'b0);
        chk("charge sw", charge_switch_o, 1'b1);
        chk("req current", charge_current_req_o, chg_alg_current_i);
        current_ma_i = 16'sh0000;
    endtask
    task automatic t_fault();
        for (int i = 0; i < 4; i++) begin
            {overcurrent_dsg_flag_i, overcurrent_dsg_tier2_flag_i, afe_overcurrent_dsg_flag_i,
                afe_short_dsg_flag_i} = 4'h1 << i;
            step(1);
            chk("dsg fault", discharge_current_fault_flag_o, 1'b1);
        end
        {overcurrent_dsg_flag_i, overcurrent_dsg_tier2_flag_i, afe_overcurrent_dsg_flag_i, afe_short_dsg_flag_i} = '0;
        step(2);
        chk("dsg fault", discharge_current_fault_flag_o, 1'b0);
        chk("dsg alarm", terminate_discharge_alarm_o, 1'b0);
    endtask
    task automatic t_removed();
        inserted = 1'b0;
        for (int k = 0; k < 4 * TP && mode_o !== MODE_REMOVED; k++) step(1);
        step(2);
        chk("mode", mode_o, MODE_REMOVED);
        chk("present", pack_present_flag_o, 1'b0);
        chk("alarms", {terminate_charge_alarm_o, terminate_discharge_alarm_o}, 2'b11);
        chk("switches", {charge_switch_o, discharge_switch_o}, 2'b00);
        chk("req current", charge_current_req_o, 16'h0000);
        inserted = 1'b1;
        for (int k = 0; k < 4 * TP && mode_o !== MODE_NORMAL; k++) step(1);
        step(2);
        chk("mode", mode_o, MODE_NORMAL);
        chk("present", pack_present_flag_o, 1'b1);
        chk("alarms", {terminate_charge_alarm_o, terminate_discharge_alarm_o}, 2'b00);
    endtask
    task automatic t_sleep();
        {no_removal_option_i, sleep_en_i, permanent_failure_flag_i} = 3'b111;
        cal_seen = 1'b0;
        step(10 * TP);
        chk("mode", mode_o, MODE_NORMAL);
        permanent_failure_flag_i = 1'b0;
        for (int k = 0; k < 10 * TP && mode_o !== MODE_SLEEP; k++) step(1);
        step(2);
        chk("mode", mode_o, MODE_SLEEP);
        chk("charge sw", charge_switch_o, 1'b0);
        chk("cal start", cal_seen, 1'b1);
        bus_clock_pin_i = 1'b1;
        for (int k = 0; k < 10 && mode_o === MODE_SLEEP; k++) step(1);
        chk("mode", mode_o, MODE_NORMAL);
    endtask
    task automatic t_shutdown();
        voltage_mv_i = 16'h1770; // below the shutdown threshold, zero current
        for (int k = 0; k < 4 * TP && mode_o !== MODE_SHUTDOWN; k++) step(1);
        step(2);
        chk("mode", mode_o, MODE_SHUTDOWN);
        chk("switches", {charge_switch_o, discharge_switch_o, zero_volt_charge_switch_o}, 3'b000);
        chk("afe shutdown", afe_shutdown_o, 1'b1);
    endtask
    // ***
    // main sequence and watchdog
    // ***
    initial begin
        {pulse_charge_off_flag_i, overcurrent_dsg_flag_i, overcurrent_dsg_tier2_flag_i, afe_overcurrent_dsg_flag_i,
            afe_short_dsg_flag_i, overcurrent_chg_flag_i, overcurrent_chg_tier2_flag_i, afe_short_chg_flag_i,
            permanent_failure_flag_i, recovery_timer_active_i, status_change_i, sleep_cmd_i, shutdown_cmd_i,
            no_removal_option_i, no_removal_keep_charge_i, sleep_en_i, bus_clock_pin_i, bus_data_pin_i} = '0;
        {precharge_phase_flag_i, precharge_timeout_action_en_i, zero_volt_cfg_hi_i, zero_volt_cfg_lo_i} = 4'hf;
        {chg_alg_chg_on_i, chg_alg_dsg_on_i, chg_alg_zv_on_i, inserted, cal_seen} = 5'h1e;
        {current_ma_i, precharge_timeout_limit_i} = '0; // zero limit: timeout off
        {voltage_mv_i, pack_mv_i} = {16'h3a98, 16'h3a98};
        {chg_thresh_ma_i, dsg_thresh_ma_i} = {16'sh0064, -16'sh03e8};
        {temp_dk_i, cal_inhibit_lo_i, cal_inhibit_hi_i} = {16'sh0258, 16'sh01c2, 16'sh0032};
        {shutdown_mv_i, charger_present_mv_i} = {SHUTDOWN_MV_RST, 16'h41a0};
        {chg_alg_current_i, chg_alg_voltage_i} = {16'h07d0, 16'h3390};
        {sleep_ma_i, sleep_v_time_i, sleep_i_time_i, bus_low_time_i} = {8'h0a, SLEEP_V_RST, SLEEP_I_RST, BUS_LOW_RST};
        repeat (12) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_wake();
        t_precharge();
        t_fault();
        t_removed();
        t_sleep();
        t_shutdown();
        wrap_up();
    end
    initial begin
        repeat (200 * TP) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end
endmodule
bind power_mode_precharge_ctl power_mode_precharge_ctl_sva power_mode_precharge_ctl_sva_inst (.*);
